// >>> logic/interval_timer_free_running_counter.sv
// interval timer with free running counter on the internal io bus
//
// Summary of operation
// - respond only to instructions carrying device address 047
// - decode transfers, vector output, interrupt enable or inhibit, initialize
// - issue interval increment request and overflow request
// - 16-bit free running counter advances per tick, wraps, readable anytime
// - free running tick source chosen by wiring, line frequency by default
// - divide the 1.1 MHz cpu clock by 110 into 10 kHz
// - interval source is 10 kHz, line frequency or external, by wiring
// - 12-bit select register, interval counter and zero detector set rate
// - interval rate equals source over count, count 10 after reset
// - software loads the count; 1 to 4095 accepted
// - overflow request when incremented word 045 holds 040001
// - each request is latched until the cpu services it
// - interval request is presented before overflow request
// - sits third in priority chain, yielding to higher devices
// - six external control commands and two transfer commands
// - external control function 0 clears the free running counter
// - divider reset by command, data out to select, or system reset
`timescale 1ns/1ps
module interval_timer_free_running_counter #(
   parameter rtc_pkg::source_type FRC_SOURCE      = rtc_pkg::SRC_LINE,
   parameter rtc_pkg::source_type INTERVAL_SOURCE = rtc_pkg::SRC_10K
) (
   // clock and reset
   input  wire logic                    mclk,
   input  wire logic                    srst,
   // internal io bus
   input  wire rtc_pkg::bus_cycle_type  bus_cycle,
   output rtc_pkg::bus_answer_type      bus_answer,
   // priority chain
   input  wire logic                    prio_in,
   output logic                         prio_out,
   // timing inputs
   input  wire logic                    cpu_clock,
   input  wire logic                    line_freq,
   input  wire logic                    external_src
);
   import rtc_pkg::*;

   // elaboration check on wiring choices
   if (INTERVAL_SOURCE == SRC_INTERVAL) begin : g_bad_source
      $error("interval logic cannot be clocked by its own rate");
   end

   typedef struct packed {
      logic [FRC_WIDTH-1:0]    free_running_count;
      logic [SELECT_WIDTH-1:0] select;
      logic [SELECT_WIDTH-1:0] interval_cnt;
      logic [6:0]              div_cnt;
      logic                    cpu_prev;
      logic                    line_prev;
      logic                    ext_prev;
      logic                    ovf_enable;
      logic                    vi_enable;
      logic                    iv_pend;
      logic                    ov_pend;
      logic                    read_valid;
      logic [15:0]             read_data;
      logic [15:0]             vector;
      logic                    request;
   } state_type;

   localparam logic [6:0] DIV_LAST = 7'(DIVIDE_RATIO - 1);

   state_type state;
   state_type next_state;

   // picks one tick among the available sources
   function automatic logic pick_tick(input source_type src, input logic line_t,
                                      input logic ext_t, input logic k10_t, input logic iv_t);
      case (src)
         SRC_LINE:     pick_tick = line_t;
         SRC_EXTERNAL: pick_tick = ext_t;
         SRC_10K:      pick_tick = k10_t;
         default:      pick_tick = iv_t;
      endcase
   endfunction : pick_tick

   logic addressed;
   logic exc_cmd;
   logic din_cmd;
   logic dout_cmd;
   logic ack_cmd;
   logic cpu_rise;
   logic tick_10k;
   logic line_tick;
   logic ext_tick;
   logic interval_tick;
   logic interval_fire;
   logic frc_tick;
   logic ack_interval;
   logic ack_overflow;

   // instruction decode
   assign addressed = bus_cycle.valid && bus_cycle.addr == DEVICE_ADDR;
   assign exc_cmd   = addressed && bus_cycle.kind == CYC_EXTERNAL_CONTROL;
   assign din_cmd   = addressed && bus_cycle.kind == CYC_DATA_IN;
   assign dout_cmd  = addressed && bus_cycle.kind == CYC_DATA_OUT;
   assign ack_cmd   = bus_cycle.valid && bus_cycle.kind == CYC_INT_ACK && state.request;

   // edge detectors on the timing inputs
   assign cpu_rise  = cpu_clock && !state.cpu_prev;
   assign line_tick = line_freq && !state.line_prev;
   assign ext_tick  = external_src && !state.ext_prev;
   assign tick_10k  = cpu_rise && state.div_cnt == DIV_LAST;

   // source selection and zero detect
   assign interval_tick = pick_tick(INTERVAL_SOURCE, line_tick, ext_tick, tick_10k, 1'b0);
   assign interval_fire = interval_tick && state.interval_cnt <= 12'h001;
   assign frc_tick      = pick_tick(FRC_SOURCE, line_tick, ext_tick, tick_10k, interval_fire);

   // acknowledge goes to the vector being shown
   assign ack_interval = ack_cmd && state.vector == INTERVAL_VECTOR;
   assign ack_overflow = ack_cmd && state.vector == OVERFLOW_VECTOR;

   // next state
   always_comb begin
      next_state            = state;
      next_state.cpu_prev   = cpu_clock;
      next_state.line_prev  = line_freq;
      next_state.ext_prev   = external_src;
      next_state.read_valid = 1'b0;
      // divide by 110
      if (exc_cmd && bus_cycle.func == FN_RESET_DIVIDE || dout_cmd) begin
         next_state.div_cnt = 7'h00;
      end else if (cpu_rise) begin
         next_state.div_cnt = tick_10k ? 7'h00 : state.div_cnt + 7'h01;
      end
      // free running counter
      if (exc_cmd && bus_cycle.func == FN_CLEAR_COUNT) begin
         next_state.free_running_count = '0;
      end else if (frc_tick) begin
         next_state.free_running_count = state.free_running_count + 16'h0001;
      end
      // interrupt enables
      if (exc_cmd) begin
         case (bus_cycle.func)
            FN_ENABLE: begin
               next_state.ovf_enable = 1'b1;
               next_state.vi_enable  = 1'b1;
            end
            FN_DISABLE_A, FN_DISABLE_B, FN_DISABLE_C: begin
               next_state.ovf_enable = 1'b0;
               next_state.vi_enable  = 1'b0;
            end
            default: ;
         endcase
      end
      // select register and interval counter
      if (dout_cmd && bus_cycle.data[SELECT_WIDTH-1:0] != 12'h000) begin
         next_state.select       = bus_cycle.data[SELECT_WIDTH-1:0];
         next_state.interval_cnt = bus_cycle.data[SELECT_WIDTH-1:0];
      end else if (interval_fire) begin
         next_state.interval_cnt = state.select;
      end else if (interval_tick) begin
         next_state.interval_cnt = state.interval_cnt - 12'h001;
      end
      // transfer of the counter to the cpu
      if (din_cmd) begin
         next_state.read_valid = 1'b1;
         next_state.read_data  = state.free_running_count;
      end
      // request latches, set wins over clear
      if (ack_interval) begin
         next_state.iv_pend = 1'b0;
      end
      if (ack_overflow) begin
         next_state.ov_pend = 1'b0;
      end
      if (ack_interval && state.ovf_enable && bus_cycle.data == OVERFLOW_WORD) begin
         next_state.ov_pend = 1'b1;
      end
      if (interval_fire && state.vi_enable) begin
         next_state.iv_pend = 1'b1;
      end
      // presented request, interval first
      next_state.request = (next_state.iv_pend || next_state.ov_pend) && !prio_in;
      next_state.vector  = next_state.iv_pend ? INTERVAL_VECTOR : OVERFLOW_VECTOR;
      if (srst) begin
         next_state              = '0;
         next_state.select       = SELECT_RESET;
         next_state.interval_cnt = SELECT_RESET;
         next_state.vector       = OVERFLOW_VECTOR;
         // follow the pins so no false edge comes out of reset
         next_state.cpu_prev     = cpu_clock;
         next_state.line_prev    = line_freq;
         next_state.ext_prev     = external_src;
      end
   end

   // state register
   always_ff @(posedge mclk) begin
      state <= next_state;
   end

   // outputs
   assign bus_answer.read_valid  = state.read_valid;
   assign bus_answer.read_data   = state.read_data;
   assign bus_answer.int_request = state.request;
   assign bus_answer.int_vector  = state.request ? state.vector : 16'h0000;
   assign prio_out               = prio_in || state.iv_pend || state.ov_pend;

   // checks
   a_foreign_ignored: assert property (@(posedge mclk) disable iff (srst)
      bus_cycle.valid && bus_cycle.addr != DEVICE_ADDR && bus_cycle.kind == CYC_DATA_IN |=> !state.read_valid)
      else $error("foreign address produced a read");
   a_read_count: assert property (@(posedge mclk) disable iff (srst)
      din_cmd && !frc_tick |=> state.read_valid && state.read_data == $past(state.free_running_count))
      else $error("read did not return counter");
   a_clear_count: assert property (@(posedge mclk) disable iff (srst)
      exc_cmd && bus_cycle.func == FN_CLEAR_COUNT |=> state.free_running_count == 16'h0000)
      else $error("counter not cleared");
   a_divide_wrap: assert property (@(posedge mclk) disable iff (srst)
      tick_10k && !dout_cmd && !exc_cmd |=> state.div_cnt == 7'h00)
      else $error("divider did not wrap at 110");
   a_divide_reset: assert property (@(posedge mclk) disable iff (srst)
      dout_cmd |=> state.div_cnt == 7'h00)
      else $error("divider not reset by data out");
   a_interval_reload: assert property (@(posedge mclk) disable iff (srst)
      interval_fire && !dout_cmd |=> state.interval_cnt == $past(state.select))
      else $error("interval counter not reloaded");
   a_interval_latch: assert property (@(posedge mclk) disable iff (srst)
      interval_fire && state.vi_enable |=> state.iv_pend ##1 (state.request || $past(prio_in) || $past(ack_interval)))
      else $error("interval request not latched");
   a_interval_first: assert property (@(posedge mclk) disable iff (srst)
      state.request && state.iv_pend |-> bus_answer.int_vector == INTERVAL_VECTOR)
      else $error("overflow shown ahead of interval");
   a_overflow_detect: assert property (@(posedge mclk) disable iff (srst)
      ack_interval && state.ovf_enable && bus_cycle.data == OVERFLOW_WORD |=> state.ov_pend)
      else $error("overflow word missed");
   a_zero_refused: assert property (@(posedge mclk) disable iff (srst)
      state.select != 12'h000)
      else $error("select count reached zero");
   c_interval_fire: cover property (@(posedge mclk) disable iff (srst) interval_fire && state.vi_enable);
   c_both_pending: cover property (@(posedge mclk) disable iff (srst) state.iv_pend && state.ov_pend);
   c_overflow_ack: cover property (@(posedge mclk) disable iff (srst) ack_overflow);
endmodule : interval_timer_free_running_counter

// >>> logic/rtc_pkg.sv
// shared constants and types for the interval timer and free running counter
package rtc_pkg;
   localparam logic [5:0]  DEVICE_ADDR     = 6'h27;   // octal 047
   localparam logic [15:0] INTERVAL_VECTOR = 16'h0024; // octal 044
   localparam logic [15:0] OVERFLOW_VECTOR = 16'h0026; // octal 046
   localparam logic [15:0] OVERFLOW_WORD   = 16'h4001; // octal 040001
   localparam int          FRC_WIDTH       = 16;
   localparam int          SELECT_WIDTH    = 12;
   localparam logic [11:0] SELECT_RESET    = 12'h00a; // factory count 10
   localparam int          DIVIDE_RATIO    = 110;
   localparam real         CPU_CLOCK_MHZ   = 1.1;
   localparam real         MCLK_MHZ        = 10.0;
   // mclk cycles per 1.1 MHz half period, rounded to the nearest whole cycle
   localparam int          CPU_HALF_CYCLES = int'(MCLK_MHZ / CPU_CLOCK_MHZ / 2.0);

   // external control functions carried in the instruction
   typedef enum logic [2:0] {
      FN_CLEAR_COUNT  = 3'h0,
      FN_ENABLE       = 3'h1,
      FN_DISABLE_A    = 3'h2,
      FN_DISABLE_B    = 3'h3,
      FN_DISABLE_C    = 3'h4,
      FN_SPARE        = 3'h5,
      FN_RESET_DIVIDE = 3'h6,
      FN_UNUSED       = 3'h7
   } exc_func_type;

   // kinds of bus cycle seen from the cpu
   typedef enum logic [1:0] {
      CYC_EXTERNAL_CONTROL = 2'h0,
      CYC_DATA_IN          = 2'h1,
      CYC_DATA_OUT         = 2'h2,
      CYC_INT_ACK          = 2'h3
   } cycle_kind_type;

   // timing sources chosen by wiring
   typedef enum logic [1:0] {
      SRC_LINE     = 2'h0,
      SRC_EXTERNAL = 2'h1,
      SRC_10K      = 2'h2,
      SRC_INTERVAL = 2'h3
   } source_type;

   // one instruction or acknowledge cycle on the internal io bus
   typedef struct packed {
      logic           valid;
      cycle_kind_type kind;
      logic [5:0]     addr;
      exc_func_type   func;
      logic [15:0]    data;
   } bus_cycle_type;

   // answer of the clock towards the cpu
   typedef struct packed {
      logic        read_valid;
      logic [15:0] read_data;
      logic        int_request;
      logic [15:0] int_vector;
   } bus_answer_type;
endpackage : rtc_pkg

// >>> bench/cpu_model.sv
// cpu side model: io bus cycles, interrupt service, timing inputs
`timescale 1ns/1ps
module cpu_model
   import rtc_pkg::*;
(
   // clock
   input  wire logic                    mclk,
   // internal io bus
   output rtc_pkg::bus_cycle_type       bus_cycle,
   input  wire rtc_pkg::bus_answer_type bus_answer,
   // timing inputs
   output logic                         cpu_clock,
   output logic                         line_freq,
   output logic                         external_src
);
   int          half_count = 0;
   logic [15:0] interval_word = 16'h0000; // host word 045

   // idle levels at time zero
   initial begin
      bus_cycle = '0;
      cpu_clock = 1'b0;
      line_freq = 1'b0;
      external_src = 1'b0;
   end

   // 1 mhz square wave from the cpu, 5 mclk per half period
   always @(posedge mclk) begin
      half_count <= (half_count == CPU_HALF_CYCLES - 1) ? 0 : half_count + 1;
      if (half_count == CPU_HALF_CYCLES - 1) cpu_clock <= ~cpu_clock;
   end

   // one bus cycle; released address and data lines show inverted values
   task automatic issue(input cycle_kind_type kind, input logic [5:0] addr, input exc_func_type func,
                        input logic [15:0] data);
      @(posedge mclk);
      bus_cycle <= '{1'b1, kind, addr, func, data};
      @(posedge mclk);
      bus_cycle <= '{1'b0, kind, ~addr, func, ~data};
   endtask : issue

   // acknowledge presented vector; interval bumps word 045
   task automatic service();
      if (bus_answer.int_vector === INTERVAL_VECTOR) interval_word = interval_word + 16'h0001;
      issue(CYC_INT_ACK, 6'h00, FN_SPARE, interval_word);
   endtask : service

   // slow line frequency pulses, then settle time
   task automatic line_pulses(input int n);
      repeat (n) begin
         repeat (2) @(posedge mclk);
         line_freq <= 1'b1;
         repeat (2) @(posedge mclk);
         line_freq <= 1'b0;
      end
      repeat (4) @(posedge mclk);
   endtask : line_pulses
endmodule : cpu_model

// >>> bench/test_interval_timer_free_running_counter.sv
// self-checking bench for the interval timer
`timescale 1ns/1ps
module test_interval_timer_free_running_counter;
   import rtc_pkg::*;
   logic           mclk = 1'b0;
   logic           srst = 1'b1;
   logic           prio_in = 1'b0;
   logic           prio_out, cpu_clock, line_freq, external_src;
   bus_cycle_type  bus_cycle;
   bus_answer_type bus_answer;
   int             fail_count = 0;
   int             compares = 0;
   int             n;

   always #50 mclk = ~mclk;

   interval_timer_free_running_counter dut (
      .mclk(mclk), .srst(srst), .bus_cycle(bus_cycle), .bus_answer(bus_answer),
      .prio_in(prio_in), .prio_out(prio_out), .cpu_clock(cpu_clock),
      .line_freq(line_freq), .external_src(external_src));

   cpu_model cpu (
      .mclk(mclk), .bus_cycle(bus_cycle), .bus_answer(bus_answer), .cpu_clock(cpu_clock),
      .line_freq(line_freq), .external_src(external_src));

   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      compares++;
      if (seen !== want) begin
         fail_count++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask : check

   task automatic tally_and_finish();
      if (fail_count == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : tally_and_finish

   // helpers: control command, counter read, bounded waits
   task automatic ctl(input exc_func_type f);
      cpu.issue(CYC_EXTERNAL_CONTROL, DEVICE_ADDR, f, 16'h0000);
   endtask : ctl

   task automatic read_count(input logic [5:0] addr, input logic ok, input logic [15:0] want);
      cpu.issue(CYC_DATA_IN, addr, FN_SPARE, 16'h0000);
      #1;
      check(bus_answer.read_valid, ok);
      if (ok) check(bus_answer.read_data, want);
   endtask : read_count

   task automatic wait_vec(input logic [15:0] want, input int limit);
      n = 0;
      while (bus_answer.int_vector !== want && n < limit) begin
         @(posedge mclk);
         #1;
         n++;
      end
   endtask : wait_vec

   task automatic expect_req(input int lo, input int hi);
      wait_vec(INTERVAL_VECTOR, hi + 5);
      check(16'(n >= lo && n <= hi), 16'h0001);
      check(bus_answer.int_request, 1'b1);
   endtask : expect_req

   task automatic serve();
      cpu.service();
      @(posedge mclk);
      #1;
      check(bus_answer.int_request, 1'b0);
   endtask : serve

   // scenarios
   task automatic test_counter();
      cpu.line_pulses(5);
      read_count(DEVICE_ADDR, 1'b1, 16'h0005);
      read_count(6'h26, 1'b0, 16'h0000);
      cpu.issue(CYC_EXTERNAL_CONTROL, 6'h26, FN_CLEAR_COUNT, 16'h0000);
      read_count(DEVICE_ADDR, 1'b1, 16'h0005);
      ctl(FN_CLEAR_COUNT);
      cpu.line_pulses(3);
      ctl(FN_SPARE);
      ctl(FN_UNUSED);
      read_count(DEVICE_ADDR, 1'b1, 16'h0003);
   endtask : test_counter

   task automatic test_rates();
      cpu.issue(CYC_DATA_OUT, DEVICE_ADDR, FN_SPARE, 16'h0002);
      expect_req(2186, 2204);
      serve();
      expect_req(2186, 2204);
      @(posedge mclk);
      prio_in <= 1'b1;
      #1;
      check(prio_out, 1'b1);
      @(posedge mclk);
      #1;
      check(bus_answer.int_request, 1'b0);
      @(posedge mclk);
      prio_in <= 1'b0;
      @(posedge mclk);
      #1;
      check(bus_answer.int_request, 1'b1);
      serve();
      // zero count refused, period of two ticks stays
      cpu.issue(CYC_DATA_OUT, DEVICE_ADDR, FN_SPARE, 16'h0000);
      expect_req(2186, 2204);
      serve();
   endtask : test_rates

   task automatic test_overflow();
      cpu.interval_word = 16'h4000;
      wait_vec(INTERVAL_VECTOR, 2300);
      check(bus_answer.int_vector, INTERVAL_VECTOR);
      cpu.service();
      repeat (3) @(posedge mclk);
      #1;
      check(bus_answer.int_vector, OVERFLOW_VECTOR);
      wait_vec(INTERVAL_VECTOR, 2300);
      check(bus_answer.int_vector, INTERVAL_VECTOR);
      cpu.service();
      repeat (2) @(posedge mclk);
      #1;
      check(bus_answer.int_vector, OVERFLOW_VECTOR);
      serve();
   endtask : test_overflow

   task automatic test_disable();
      for (int f = 2; f <= 4; f++) begin
         ctl(exc_func_type'(3'(f)));
         wait_vec(INTERVAL_VECTOR, 2300);
         check(bus_answer.int_request, 1'b0);
         ctl(FN_ENABLE);
         wait_vec(INTERVAL_VECTOR, 2300);
         check(bus_answer.int_vector, INTERVAL_VECTOR);
         serve();
      end
   endtask : test_disable

   task automatic test_divider_reset();
      cpu.issue(CYC_DATA_OUT, DEVICE_ADDR, FN_SPARE, 16'h0001);
      expect_req(1088, 1106);
      serve();
      repeat (500) @(posedge mclk);
      ctl(FN_RESET_DIVIDE);
      expect_req(1088, 1106);
      serve();
   endtask : test_divider_reset

   // reset in mid-run with a request pending
   task automatic test_reset();
      wait_vec(INTERVAL_VECTOR, 1200);
      check(bus_answer.int_vector, INTERVAL_VECTOR);
      @(posedge mclk);
      srst <= 1'b1;
      repeat (2) @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      #1;
      check(bus_answer.int_request, 1'b0);
      check(prio_out, 1'b0);
      @(posedge mclk);
      prio_in <= 1'b1;
      #1;
      check(prio_out, 1'b1);
      @(posedge mclk);
      prio_in <= 1'b0;
      read_count(DEVICE_ADDR, 1'b1, 16'h0000);
      ctl(FN_ENABLE);
      expect_req(10975, 11005);
      serve();
   endtask : test_reset

   // main sequence
   initial begin
      repeat (3) @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      #1;
      check(bus_answer.int_vector, 16'h0000);
      check(prio_out, 1'b0);
      read_count(DEVICE_ADDR, 1'b1, 16'h0000);
      ctl(FN_ENABLE);
      expect_req(10975, 11005);
      serve();
      test_counter();
      test_rates();
      test_overflow();
      test_disable();
      test_divider_reset();
      test_reset();
      tally_and_finish();
   end

   // watchdog
   initial begin
      #(80000 * 100);
      fail_count++;
      tally_and_finish();
   end
endmodule : test_interval_timer_free_running_counter
